// file: logic/tcc_defs.vh
// Register offsets, field positions and reset values for the timer capture/compare unit.
// Overview of operation
// - Every active capture edge copies the counter into the channel value, flag set or not.
// - A channel flag that is set raises the channel interrupt when its enable is set; channel 1 only while unlinked.
// - The captured counter value is stored on the third clock edge after the pin edge.
// - A later capture overwrites the earlier value; only the newest time is kept.
// - Reset leaves the channel value registers untouched.
// - Both channels capture and compare against one shared 16-bit modulo counter.
// - A counter match sets, clears or toggles the channel pin and sets the flag.
// - Unbuffered writes replace the compare value at once; a passed value misses.
// - The link bit joins channels 0 and 1 into one buffered compare on pin 0.
// - Linked: channel 0 value rules first; each overflow hands over to the last written.
// - Linked: channel 0 control governs, channel 1 control ignored, pin 1 released.
// - Toggle-on-overflow toggles the pin when the counter reaches the modulo value.
// - Modulo 255 with undivided prescaler gives a 256 cycle period.
// - An 8-bit period gives 256 pulse width steps set by the channel value.
// - A 3-bit prescale select picks one of seven rates of the bus clock.
// - Reaching the modulo value sets the overflow flag and its interrupt if enabled.
// - Without toggle-on-overflow duty is 0%; max duty bit with toggle gives 100%.
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH
`define TCC_ADR_CTRL 5'h00
`define TCC_ADR_MOD 5'h04
`define TCC_ADR_CS0 5'h08
`define TCC_ADR_VAL0 5'h0c
`define TCC_ADR_CS1 5'h10
`define TCC_ADR_VAL1 5'h14
`define TCC_ADR_CNT 5'h18
`define TCC_B_FLAG 7
`define TCC_B_IE 6
`define TCC_B_STOP 5
`define TCC_B_PRST 4
`define TCC_B_LINK 5
`define TCC_B_MSA 4
`define TCC_B_TOV 1
`define TCC_B_MAX 0
`define TCC_MOD_RST 16'hffff
`define TCC_PS_TOP 3'h6
`endif

// file: logic/tcc_timer.v
// Two-channel capture/compare/PWM timer with an Avalon-MM register slave.
`timescale 1ns/1ps
`include "tcc_defs.vh"

module tcc_timer (
    input wire mclk_in,
    input wire rst_b_in,
    input wire [4:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output reg avs_waitrequest_out,
    input wire chan0_pin_in,
    output wire chan0_pin_out,
    output wire chan0_pin_oe_b_out,
    input wire chan1_pin_in,
    output wire chan1_pin_out,
    output wire chan1_pin_oe_b_out,
    output reg ovf_irq_out,
    output reg [1:0] chan_irq_out
);

    // Bus handshake: a request is held one cycle, then completes.
    wire req = avs_read_in | avs_write_in;
    wire acc = req & ~avs_waitrequest_out;
    wire wr = avs_write_in & acc;
    wire [4:0] adr = avs_address_in;
    wire [31:0] wd = avs_writedata_in;

    // Overflow status and timer control fields.
    reg ovf_flag;
    reg ovf_ie;
    reg stop;
    reg [2:0] ps;

    // Shared counter, its modulo and the prescaler behind it.
    reg [15:0] modulo;
    reg [15:0] cnt;
    reg [5:0] pre;

    // Channel control words and value registers.
    reg [7:0] cs [0:1];
    reg [15:0] val [0:1];

    // Linked-pair state: the value in use and the one written last.
    reg act;
    reg last;

    // Pin flops and the read mux result.
    reg [1:0] pin_q;
    reg [1:0] oe_b_q;
    reg [31:0] next_rd;

    wire lk = cs[0][`TCC_B_LINK];
    wire ctrl_wr = wr & (adr == `TCC_ADR_CTRL);
    wire prst_wr = ctrl_wr & wd[`TCC_B_PRST];

    // Prescaler: divide by 1 to 64; code 7 reuses the slowest rate.
    wire [2:0] psc = (ps > `TCC_PS_TOP) ? `TCC_PS_TOP : ps;
    wire [5:0] pmask = (6'h01 << psc) - 6'h01;
    wire tick = ~stop & ((pre & pmask) == pmask);
    wire ovf_ev = tick & (cnt == modulo);

    // Per-channel events and next pin state, filled in by the channel loop.
    wire [1:0] pins = {chan1_pin_in, chan0_pin_in};
    wire [1:0] cap_ev;
    wire [1:0] match;
    wire [1:0] cs_wr;
    wire [1:0] v_wr;
    wire [1:0] next_pin;
    wire [1:0] next_oe_b;

    assign chan0_pin_out = pin_q[0];
    assign chan1_pin_out = pin_q[1];
    assign chan0_pin_oe_b_out = oe_b_q[0];
    assign chan1_pin_oe_b_out = oe_b_q[1];

    // Per-channel edge detection, compare and pin action.
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_ch
            reg [2:0] sy;
            wire [7:0] c = cs[i];
            wire off = (i == 1) & lk;
            wire rise = sy[1] & ~sy[2];
            wire fall = ~sy[1] & sy[2];
            wire cmp_mode = ~off & (c[5] | c[4]);
            wire cap_mode = ~off & ~(c[5] | c[4]) & (c[3] | c[2]);
            wire [15:0] cval;
            wire [1:0] els = c[3:2];
            wire tov = c[`TCC_B_TOV];
            wire full = c[`TCC_B_MAX] & tov;

            // Two flops before the pin is looked at; the third is history.
            always @(posedge mclk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    sy <= 3'h0;
                end else begin
                    sy <= {sy[1:0], pins[i]};
                end
            end

            // Linked channel 0 compares against whichever value is active.
            assign cval = (i == 0 && lk && act) ? val[1] : val[i];
            assign cap_ev[i] = cap_mode & ((c[2] & rise) | (c[3] & fall));
            assign match[i] = cmp_mode & tick & (cnt == cval);
            assign cs_wr[i] = wr & (adr == (i ? `TCC_ADR_CS1 : `TCC_ADR_CS0));
            assign v_wr[i] = wr & (adr == (i ? `TCC_ADR_VAL1 : `TCC_ADR_VAL0));

            // Max duty forces high; compare beats the overflow toggle.
            // A fixed order keeps the pin deterministic when both events land on one tick.
            reg npin;
            always @* begin
                npin = pin_q[i];
                if (cmp_mode) begin
                    if (full) begin
                        npin = 1'b1;
                    end else if (match[i] & (els != 2'h0)) begin
                        case (els)
                            2'h1: npin = ~pin_q[i];
                            2'h2: npin = 1'b0;
                            2'h3: npin = 1'b1;
                            default: npin = pin_q[i];
                        endcase
                    end else if (ovf_ev & tov) begin
                        npin = ~pin_q[i];
                    end
                end
            end
            assign next_pin[i] = npin;
            assign next_oe_b[i] = ~(cmp_mode & (els != 2'h0));
        end
    endgenerate

    // Waitrequest drops for one cycle per request, so every transfer takes two edges.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            avs_waitrequest_out <= 1'b1;
        end else begin
            avs_waitrequest_out <= ~(req & avs_waitrequest_out);
        end
    end

    // Read data is captured while waitrequest is still high and stands until the next read.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            avs_readdata_out <= 32'h0;
        end else if (avs_read_in & avs_waitrequest_out) begin
            avs_readdata_out <= next_rd;
        end
    end

    // Read mux; unmapped offsets read zero and have no side effect.
    always @* begin
        case (adr)
            `TCC_ADR_CTRL: next_rd = {24'h0, ovf_flag, ovf_ie, stop, 2'h0, ps};
            `TCC_ADR_MOD: next_rd = {16'h0, modulo};
            `TCC_ADR_CS0: next_rd = {24'h0, cs[0]};
            `TCC_ADR_VAL0: next_rd = {16'h0, val[0]};
            `TCC_ADR_CS1: next_rd = {24'h0, cs[1]};
            `TCC_ADR_VAL1: next_rd = {16'h0, val[1]};
            `TCC_ADR_CNT: next_rd = {16'h0, cnt};
            default: next_rd = 32'h0;
        endcase
    end

    // Shared counter; nothing but the prescaler reset touches it.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pre <= 6'h0;
            cnt <= 16'h0;
        end else if (prst_wr) begin
            pre <= 6'h0;
            cnt <= 16'h0;
        end else if (!stop) begin
            pre <= pre + 6'h01;
            if (tick) begin
                cnt <= (cnt == modulo) ? 16'h0 : cnt + 16'h0001;
            end
        end
    end

    // Overflow flag; a hardware set wins over a same-cycle clear so no overflow is lost.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ovf_flag <= 1'b0;
        end else if (ovf_ev) begin
            ovf_flag <= 1'b1;
        end else if (ctrl_wr & ~wd[`TCC_B_FLAG]) begin
            ovf_flag <= 1'b0;
        end
    end

    // Timer control fields.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ovf_ie <= 1'b0;
            stop <= 1'b0;
            ps <= 3'h0;
        end else if (ctrl_wr) begin
            ovf_ie <= wd[`TCC_B_IE];
            stop <= wd[`TCC_B_STOP];
            ps <= wd[2:0];
        end
    end

    // Modulo takes effect at once, so a smaller value written late can miss one period.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            modulo <= `TCC_MOD_RST;
        end else if (wr & (adr == `TCC_ADR_MOD)) begin
            modulo <= wd[15:0];
        end
    end

    // Channel controls and flags; channel 1 has no link bit.
    integer k;
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cs[0] <= 8'h0;
            cs[1] <= 8'h0;
        end else begin
            for (k = 0; k < 2; k = k + 1) begin
                if (cs_wr[k]) begin
                    cs[k][6:0] <= (k == 1) ? (wd[6:0] & 7'h5f) : wd[6:0];
                end
                if (cap_ev[k] | match[k]) begin
                    cs[k][7] <= 1'b1;
                end else if (cs_wr[k] & ~wd[`TCC_B_FLAG]) begin
                    cs[k][7] <= 1'b0;
                end
            end
        end
    end

    // Value registers have no reset so their contents survive it.
    always @(posedge mclk_in) begin
        for (k = 0; k < 2; k = k + 1) begin
            if (cap_ev[k]) begin
                val[k] <= cnt;
            end else if (v_wr[k]) begin
                val[k] <= wd[15:0];
            end
        end
    end

    // Remembers which value register of the linked pair was written last.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            last <= 1'b0;
        end else if (!lk) begin
            last <= 1'b0;
        end else if (v_wr[0]) begin
            last <= 1'b0;
        end else if (v_wr[1]) begin
            last <= 1'b1;
        end
    end

    // Buffered handover happens only at overflow, so a period is never cut short.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            act <= 1'b0;
        end else if (!lk) begin
            act <= 1'b0;
        end else if (ovf_ev) begin
            act <= last;
        end
    end

    // Pin drive and enable come from flops, so the pads never see decode glitches.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pin_q <= 2'h0;
            oe_b_q <= 2'h3;
        end else begin
            pin_q <= next_pin;
            oe_b_q <= next_oe_b;
        end
    end

    // Interrupt requests are levels; software drops them by clearing the flag.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ovf_irq_out <= 1'b0;
            chan_irq_out <= 2'h0;
        end else begin
            ovf_irq_out <= ovf_flag & ovf_ie;
            chan_irq_out[0] <= cs[0][7] & cs[0][6];
            chan_irq_out[1] <= cs[1][7] & cs[1][6] & ~lk;
        end
    end

endmodule // tcc_timer

// file: bench/tcc_pin_src.sv
// Model of the outside circuit on one channel pin.
`timescale 1ns/1ps
module tcc_pin_src (
    input wire oe_b_in,
    input wire drv_in,
    input wire src_in,
    output wire line_out
);
    // The outside source drives the line whenever the timer releases it.
    assign line_out = oe_b_in ? src_in : drv_in;
endmodule // tcc_pin_src

// file: bench/tcc_timer_sva.sv
// Checker for the timer's bus handshake, interrupt enables and channel linking.
`timescale 1ns/1ps
module tcc_timer_sva (
    input wire mclk_in,
    input wire rst_b_in,
    input wire [4:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    input wire chan1_pin_oe_b_out,
    input wire ovf_irq_out,
    input wire [1:0] chan_irq_out
);
    reg [7:0] ctl;
    reg [7:0] cs0;
    wire wdone = avs_write_in && !avs_waitrequest_out;
    wire rdone = avs_read_in && !avs_waitrequest_out;
    // Shadow copies of the enables, taken only from writes that complete.
    always @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ctl <= 8'h00;
            cs0 <= 8'h00;
        end else if (wdone && avs_address_in == 5'h00) begin
            ctl <= avs_writedata_in[7:0];
        end else if (wdone && avs_address_in == 5'h08) begin
            cs0 <= avs_writedata_in[7:0];
        end
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);
    sequence s_req;
        (avs_read_in || avs_write_in) && avs_waitrequest_out;
    endsequence
    sequence s_ack;
        !avs_waitrequest_out ##1 avs_waitrequest_out;
    endsequence
    a_req_answer: assert property (s_req |=> s_ack) else $error("request not answered in one cycle");
    a_idle_wait: assert property (!avs_read_in && !avs_write_in |=> avs_waitrequest_out) else $error("wait low at idle");
    a_rd_unmapped: assert property (rdone && avs_address_in > 5'h18 |-> avs_readdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_rd_upper: assert property (rdone |-> avs_readdata_out[31:16] == 16'h0) else $error("upper read bits set");
    a_ovf_irq_off: assert property (!ctl[6] [*2] |-> !ovf_irq_out) else $error("overflow irq while disabled");
    a_ch0_irq_off: assert property (!cs0[6] [*2] |-> !chan_irq_out[0]) else $error("ch0 irq while disabled");
    a_link_irq_off: assert property (cs0[5] [*2] |-> !chan_irq_out[1]) else $error("ch1 irq while linked");
    a_link_pin_free: assert property (cs0[5] [*3] |-> chan1_pin_oe_b_out) else $error("ch1 pin driven while linked");
endmodule // tcc_timer_sva
bind tcc_timer tcc_timer_sva chk (.mclk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .chan1_pin_oe_b_out, .ovf_irq_out, .chan_irq_out);

// file: bench/tb.sv
// Self-checking bench for the two-channel capture/compare timer.
`timescale 1ns/1ps
module tb;
    reg mclk_in = 1'b0;
    reg rst_b_in = 1'b0;
    reg [4:0] avs_address_in = 5'h00;
    reg avs_read_in = 1'b0;
    reg avs_write_in = 1'b0;
    reg [31:0] avs_writedata_in = 32'h0;
    reg src0 = 1'b0;
    reg src1 = 1'b0;
    wire [31:0] avs_readdata_out;
    wire avs_waitrequest_out, chan0_pin_in, chan0_pin_out, chan0_pin_oe_b_out;
    wire chan1_pin_in, chan1_pin_out, chan1_pin_oe_b_out, ovf_irq_out;
    wire [1:0] chan_irq_out;
    integer n_fail = 0;
    integer cmp_count = 0;
    integer cyc = 0;
    integer i, hi;
    reg [31:0] q, c0;
    reg [36:0] rows [0:4];
    tcc_timer uut (.mclk_in, .rst_b_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_readdata_out, .avs_waitrequest_out, .chan0_pin_in, .chan0_pin_out, .chan0_pin_oe_b_out,
        .chan1_pin_in, .chan1_pin_out, .chan1_pin_oe_b_out, .ovf_irq_out, .chan_irq_out);
    tcc_pin_src m0 (.oe_b_in(chan0_pin_oe_b_out), .drv_in(chan0_pin_out), .src_in(src0), .line_out(chan0_pin_in));
    tcc_pin_src m1 (.oe_b_in(chan1_pin_oe_b_out), .drv_in(chan1_pin_out), .src_in(src1), .line_out(chan1_pin_in));
    // Clock of 8 ns.
    always #4 mclk_in = ~mclk_in;
    // A hang is cut short well past the expected run length.
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            results;
        end
    end
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("mismatch %0s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    // One Avalon transfer; the request stands until waitrequest is sampled low.
    task bus(input w, input [4:0] a, input [31:0] d);
        begin
            @(posedge mclk_in);
            avs_address_in <= a;
            avs_writedata_in <= d;
            avs_write_in <= w;
            avs_read_in <= !w;
            @(posedge mclk_in);
            while (avs_waitrequest_out) @(posedge mclk_in);
            q = avs_readdata_out;
            avs_write_in <= 1'b0;
            avs_read_in <= 1'b0;
        end
    endtask
    // High time of pin 0 over one 256-cycle window, after settling.
    task duty;
        begin
            repeat (600) @(posedge mclk_in);
            hi = 0;
            repeat (256) @(posedge mclk_in) hi = hi + (chan0_pin_in === 1'b1);
        end
    endtask
    task results;
        begin
            $display("counts: %0d compares, %0d mismatches", cmp_count, n_fail);
            if (n_fail == 0 && cmp_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    initial begin
        rows[0] = {5'h00, 32'h0};
        rows[1] = {5'h04, 32'hffff};
        rows[2] = {5'h08, 32'h0};
        rows[3] = {5'h10, 32'h0};
        rows[4] = {5'h1c, 32'h0};
        repeat (2) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        for (i = 0; i < 5; i = i + 1) begin
            bus(1'b0, rows[i][36:32], 32'h0);
            chk("reset value", q, rows[i][31:0]);
        end
        $display("register reset test done");
        // A stored value survives a second reset.
        bus(1'b1, 5'h0c, 32'h1234);
        @(posedge mclk_in);
        rst_b_in <= 1'b0;
        @(posedge mclk_in);
        rst_b_in <= 1'b1;
        bus(1'b0, 5'h0c, 32'h0);
        chk("value after reset", q, 32'h1234);
        // Modulo 255, undivided clock, counter restarted; both channels capture rising edges.
        bus(1'b1, 5'h04, 32'hff);
        bus(1'b1, 5'h00, 32'h10);
        bus(1'b1, 5'h08, 32'h04);
        bus(1'b1, 5'h10, 32'h44);
        @(posedge mclk_in);
        src0 <= 1'b1;
        repeat (300) @(posedge mclk_in);
        src1 <= 1'b1;
        repeat (10) @(posedge mclk_in);
        src1 <= 1'b0;
        repeat (10) @(posedge mclk_in);
        src1 <= 1'b1;
        repeat (10) @(posedge mclk_in);
        bus(1'b0, 5'h0c, 32'h0);
        c0 = q;
        bus(1'b0, 5'h14, 32'h0);
        chk("capture time", q, (c0 + 32'd320) & 32'hff);
        chk("capture irq", chan_irq_out[1], 1'b1);
        $display("capture test done");
        // Clear-on-compare with toggle on overflow gives a high pulse of the compare width.
        bus(1'b1, 5'h0c, 32'h40);
        bus(1'b1, 5'h08, 32'h1a);
        bus(1'b1, 5'h00, 32'h40);
        duty;
        chk("duty 40", hi >= 64 && hi <= 65, 1'b1);
        chk("overflow irq", ovf_irq_out, 1'b1);
        @(posedge chan0_pin_in);
        c0 = $time;
        bus(1'b1, 5'h0c, 32'h80);
        @(posedge chan0_pin_in);
        chk("pwm period", $time - c0, 32'd2048);
        duty;
        chk("duty 80", hi >= 128 && hi <= 129, 1'b1);
        // A shorter pulse is written just after the compare, before the period ends.
        @(negedge chan0_pin_in);
        bus(1'b1, 5'h0c, 32'h40);
        duty;
        chk("duty back 40", hi >= 64 && hi <= 65, 1'b1);
        chk("ch0 driven", chan0_pin_oe_b_out, 1'b0);
        bus(1'b1, 5'h08, 32'h1b);
        duty;
        chk("full duty", hi, 32'd256);
        bus(1'b1, 5'h08, 32'h18);
        duty;
        chk("zero duty", hi, 32'd0);
        $display("compare test done");
        // Linked pair: channel 0 leads, the written channel 1 takes over at overflow.
        bus(1'b1, 5'h0c, 32'h20);
        bus(1'b1, 5'h08, 32'h3a);
        bus(1'b1, 5'h10, 32'h54);
        bus(1'b1, 5'h14, 32'h60);
        duty;
        chk("linked duty", hi >= 96 && hi <= 97, 1'b1);
        chk("ch1 released", chan1_pin_oe_b_out, 1'b1);
        chk("ch1 irq off", chan_irq_out[1], 1'b0);
        chk("ch1 level", chan1_pin_out, 1'b0);
        $display("linked test done");
        results;
    end
endmodule // tb
